/* rtl/twmtc_top.sv */
// two-wire master transmitter controller with cpu register port
`timescale 1ns/10ps
module twmtc_top (
  input  wire logic       MCLK_IN,
  input  wire logic       SYS_RST_IN,
  input  wire logic [7:0] SFR_ADDR_IN,
  input  wire logic       SFR_WR_IN,
  input  wire logic [7:0] SFR_WDATA_IN,
  output logic      [7:0] SFR_RDATA_OUT,
  output logic            SERIAL_IRQ_OUT,
  input  wire logic [7:0] T1_RELOAD_IN,
  input  wire logic       EXT_TICK_IN,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SCL_OUT,
  output logic            SCL_OE_OUT,
  output logic            SDA_OUT,
  output logic            SDA_OE_OUT,
  output logic      [7:0] CAP_DATA_OUT,
  output logic            CAP_VALID_OUT,
  input  wire logic       CAP_READY_IN
);

  // ---------------------------------------------------------------
  // types and storage
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_WAIT  = 7'b000_0010,
    S_START = 7'b000_0100,
    S_BIT   = 7'b000_1000,
    S_HOLD  = 7'b001_0000,
    S_STOP  = 7'b010_0000,
    S_FREE  = 7'b100_0000
  } twmtc_state_e;

  twmtc_state_e state_q;
  logic [7:0]   bcr_q;
  logic [7:0]   shift_q;
  logic [1:0]   crr_q;
  logic [7:0]   oar_q;
  logic [7:0]   code_q;
  logic [7:0]   status_q;
  logic [1:0]   phase_q;
  logic [3:0]   bitn_q;
  logic         first_q;
  logic         rep_q;
  logic         ack_q;
  logic         scl_drv_q;
  logic         sda_drv_q;
  logic         scl_prev_q;
  logic         sda_prev_q;
  logic         busy_q;
  logic [12:0]  qcnt_q;
  logic         irq_q;
  logic [7:0]   rdata_q;
  logic         pins_q;

  logic         active;
  logic         flag;
  logic         tick;
  logic [12:0]  qdiv;
  logic [8:0]   t1_span;
  logic         start_det;
  logic         stop_det;
  logic         si_set;
  logic [7:0]   si_code;
  logic         end_clr;
  logic         push_valid;
  logic         push_ready;
  logic         wr_bcr;

  assign flag   = bcr_q[twmtc_pkg::BCR_FLAG];
  assign active = bcr_q[twmtc_pkg::BCR_EN] && crr_q[twmtc_pkg::CRR_SEL];
  assign wr_bcr = SFR_WR_IN && (SFR_ADDR_IN == twmtc_pkg::BCR_ADDR);

  // ---------------------------------------------------------------
  // bit rate: quarter tick generator
  // ---------------------------------------------------------------
  assign t1_span = 9'(twmtc_pkg::T1_SPAN - {1'b0, T1_RELOAD_IN});

  always_comb begin
    case ({bcr_q[twmtc_pkg::BCR_RATE2], bcr_q[twmtc_pkg::BCR_RATE1],
           bcr_q[twmtc_pkg::BCR_RATE0]})
      3'd0:    qdiv = twmtc_pkg::QTR_R0;
      3'd1:    qdiv = twmtc_pkg::QTR_R1;
      3'd2:    qdiv = twmtc_pkg::QTR_R2;
      3'd3:    qdiv = twmtc_pkg::QTR_R3;
      3'd5:    qdiv = twmtc_pkg::QTR_R5;
      3'd6:    qdiv = twmtc_pkg::QTR_R6;
      3'd7:    qdiv = 13'(twmtc_pkg::QTR_T1 * {4'h0, t1_span});
      default: qdiv = twmtc_pkg::QTR_R0;
    endcase
  end

  // external source replaces the rate bits; floor keeps 400 kbit/s
  assign tick = (crr_q[twmtc_pkg::CRR_EXT] ? EXT_TICK_IN
                 : (qcnt_q >= qdiv - 13'd1))
                && (qcnt_q >= twmtc_pkg::MIN_QTR_CYC - 13'd1);

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      qcnt_q <= '0;
    end else if (tick) begin
      qcnt_q <= '0;
    end else if (qcnt_q != 13'h1FFF) begin
      qcnt_q <= qcnt_q + 13'd1;
    end
  end

  // ---------------------------------------------------------------
  // bus monitor: conditions and busy
  // ---------------------------------------------------------------
  assign start_det = scl_prev_q && SCL_IN && sda_prev_q && !SDA_IN;
  assign stop_det  = scl_prev_q && SCL_IN && !sda_prev_q && SDA_IN;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      busy_q     <= 1'b0;
    end else begin
      scl_prev_q <= SCL_IN;
      sda_prev_q <= SDA_IN;
      if (start_det) begin
        busy_q <= 1'b1;
      end else if (stop_det) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  assign push_valid = (state_q == S_BIT) && (bitn_q == 4'd8)
                      && (phase_q == 2'd3) && tick;

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state_q   <= S_IDLE;
      phase_q   <= 2'd0;
      bitn_q    <= 4'd0;
      first_q   <= 1'b0;
      rep_q     <= 1'b0;
      ack_q     <= 1'b1;
      scl_drv_q <= 1'b0;
      sda_drv_q <= 1'b0;
      si_set    <= 1'b0;
      si_code   <= twmtc_pkg::ST_NONE;
      end_clr   <= 1'b0;
    end else begin
      si_set  <= 1'b0;
      end_clr <= 1'b0;
      if (!active) begin
        state_q   <= S_IDLE;
        scl_drv_q <= 1'b0;
        sda_drv_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            if (bcr_q[twmtc_pkg::BCR_BEGIN] && !flag) begin
              state_q <= S_WAIT;
            end
          end
          S_WAIT: begin
            if (tick && !busy_q && SCL_IN && SDA_IN) begin
              sda_drv_q <= 1'b1;
              rep_q     <= 1'b0;
              phase_q   <= 2'd3;
              state_q   <= S_START;
            end
          end
          S_START: begin
            if (tick && (phase_q != 2'd2 || SCL_IN)) begin
              phase_q <= phase_q + 2'd1;
              case (phase_q)
                2'd0:    sda_drv_q <= 1'b0;
                2'd1:    scl_drv_q <= 1'b0;
                2'd2:    sda_drv_q <= 1'b1;
                default: begin
                  scl_drv_q <= 1'b1;
                  first_q   <= 1'b1;
                  si_set    <= 1'b1;
                  si_code   <= rep_q ? twmtc_pkg::ST_RSTART
                                     : twmtc_pkg::ST_START;
                  state_q   <= S_HOLD;
                end
              endcase
            end
          end
          S_BIT: begin
            if ((start_det || stop_det) && phase_q != 2'd0) begin
              si_set    <= 1'b1;
              si_code   <= twmtc_pkg::ST_BUS_ERR;
              scl_drv_q <= 1'b0;
              sda_drv_q <= 1'b0;
              state_q   <= S_FREE;
            end else if (tick && (phase_q != 2'd2 || SCL_IN)) begin
              phase_q <= phase_q + 2'd1;
              case (phase_q)
                2'd0: begin
                  // address direction bit and data go out as stored
                  sda_drv_q <= (bitn_q != 4'd8) && !shift_q[7];
                end
                2'd1: scl_drv_q <= 1'b0;
                2'd2: begin
                  if (bitn_q == 4'd8) begin
                    ack_q <= SDA_IN;
                  end else if (shift_q[7] && !SDA_IN) begin
                    si_set    <= 1'b1;
                    si_code   <= twmtc_pkg::ST_ARB_LOST;
                    scl_drv_q <= 1'b0;
                    sda_drv_q <= 1'b0;
                    state_q   <= S_FREE;
                  end
                end
                default: begin
                  scl_drv_q <= 1'b1;
                  if (bitn_q != 4'd8) begin
                    bitn_q <= bitn_q + 4'd1;
                  end else if (!push_ready) begin
                    phase_q <= 2'd3;
                  end else begin
                    sda_drv_q <= 1'b0;
                    si_set    <= 1'b1;
                    first_q   <= 1'b0;
                    state_q   <= S_HOLD;
                    if (first_q) begin
                      si_code <= ack_q ? twmtc_pkg::ST_ADDR_NACK
                                       : twmtc_pkg::ST_ADDR_ACK;
                    end else begin
                      si_code <= ack_q ? twmtc_pkg::ST_DATA_NACK
                                       : twmtc_pkg::ST_DATA_ACK;
                    end
                  end
                end
              endcase
            end
          end
          S_HOLD: begin
            // clock is held low until the flag is cleared
            if (!flag && !si_set) begin
              phase_q <= 2'd0;
              if (bcr_q[twmtc_pkg::BCR_END]) begin
                state_q <= S_STOP;
              end else if (bcr_q[twmtc_pkg::BCR_BEGIN]) begin
                rep_q   <= 1'b1;
                state_q <= S_START;
              end else begin
                bitn_q  <= 4'd0;
                state_q <= S_BIT;
              end
            end
          end
          S_STOP: begin
            if (tick && (phase_q != 2'd2 || SCL_IN)) begin
              phase_q <= phase_q + 2'd1;
              case (phase_q)
                2'd0:    sda_drv_q <= 1'b1;
                2'd1:    scl_drv_q <= 1'b0;
                2'd2:    sda_drv_q <= 1'b0;
                default: begin
                  end_clr <= 1'b1;
                  state_q <= S_IDLE;
                end
              endcase
            end
          end
          S_FREE: begin
            scl_drv_q <= 1'b0;
            sda_drv_q <= 1'b0;
            if (!flag && !si_set) begin
              end_clr <= bcr_q[twmtc_pkg::BCR_END];
              state_q <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // bus_control_reg
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      bcr_q <= twmtc_pkg::BCR_RST;
    end else begin
      if (end_clr) begin
        bcr_q[twmtc_pkg::BCR_END] <= 1'b0;
      end
      if (wr_bcr) begin
        // software only clears the flag; end write beats hw clear
        bcr_q[7:4] <= SFR_WDATA_IN[7:4];
        bcr_q[2:0] <= SFR_WDATA_IN[2:0];
        if (!SFR_WDATA_IN[twmtc_pkg::BCR_FLAG]) begin
          bcr_q[twmtc_pkg::BCR_FLAG] <= 1'b0;
        end
      end
      if (si_set) begin
        bcr_q[twmtc_pkg::BCR_FLAG] <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // shift_byte_reg
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      shift_q <= twmtc_pkg::SBR_RST;
    end else if (state_q == S_BIT && phase_q == 2'd2 && tick && SCL_IN
                 && bitn_q != 4'd8 && !flag) begin
      shift_q <= {shift_q[6:0], SDA_IN};
    end else if (SFR_WR_IN && SFR_ADDR_IN == twmtc_pkg::SBR_ADDR
                 && flag) begin
      shift_q <= SFR_WDATA_IN;
    end
  end

  // ---------------------------------------------------------------
  // code_and_rate_reg, own_address_reg, status
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      crr_q <= twmtc_pkg::CRR_RST;
      oar_q <= twmtc_pkg::OAR_RST;
    end else begin
      if (SFR_WR_IN && SFR_ADDR_IN == twmtc_pkg::CRR_ADDR) begin
        crr_q <= SFR_WDATA_IN[1:0];
      end
      if (SFR_WR_IN && SFR_ADDR_IN == twmtc_pkg::OAR_ADDR) begin
        oar_q <= SFR_WDATA_IN;
      end
    end
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      code_q   <= twmtc_pkg::ST_NONE;
      status_q <= twmtc_pkg::ST_NONE;
    end else begin
      if (si_set) begin
        code_q <= si_code;
      end
      // one cycle behind the flag in both directions
      status_q <= flag ? code_q : twmtc_pkg::ST_NONE;
    end
  end

  // ---------------------------------------------------------------
  // read port, interrupt request and pins
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      rdata_q <= 8'h00;
    end else begin
      case (SFR_ADDR_IN)
        twmtc_pkg::BCR_ADDR: rdata_q <= bcr_q;
        twmtc_pkg::SBR_ADDR: rdata_q <= shift_q;
        twmtc_pkg::CRR_ADDR: begin
          rdata_q <= status_q & twmtc_pkg::CODE_MASK;
        end
        twmtc_pkg::OAR_ADDR: rdata_q <= oar_q;
        default:             rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      irq_q  <= 1'b0;
      pins_q <= 1'b0;
    end else begin
      irq_q  <= flag && (code_q != twmtc_pkg::ST_NONE);
      pins_q <= 1'b0;
    end
  end

  assign SFR_RDATA_OUT  = rdata_q;
  assign SERIAL_IRQ_OUT = irq_q;
  assign SCL_OUT        = pins_q;
  assign SDA_OUT        = pins_q;
  assign SCL_OE_OUT     = scl_drv_q;
  assign SDA_OE_OUT     = sda_drv_q;

  // ---------------------------------------------------------------
  // capture fifo of bytes seen on the bus
  // ---------------------------------------------------------------
  twmtc_fifo #(
    .W     (8),
    .DEPTH (16)
  ) u_fifo (
    .clk_in        (MCLK_IN),
    .rst_in        (SYS_RST_IN),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (shift_q),
    .out_valid_out (CAP_VALID_OUT),
    .out_ready_in  (CAP_READY_IN),
    .out_data_out  (CAP_DATA_OUT)
  );

endmodule : twmtc_top

/* rtl/twmtc_pkg.sv */
// shared constants for the two-wire master transmitter controller
package twmtc_pkg;

  // ---------------------------------------------------------------
  // special function register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] BCR_ADDR = 8'hA0;
  localparam logic [7:0] SBR_ADDR = 8'hA1;
  localparam logic [7:0] CRR_ADDR = 8'hA2;
  localparam logic [7:0] OAR_ADDR = 8'hA3;

  // ---------------------------------------------------------------
  // bus_control_reg fields
  // ---------------------------------------------------------------
  localparam int BCR_RATE2 = 7;
  localparam int BCR_EN    = 6;
  localparam int BCR_BEGIN = 5;
  localparam int BCR_END   = 4;
  localparam int BCR_FLAG  = 3;
  localparam int BCR_ACK   = 2;
  localparam int BCR_RATE1 = 1;
  localparam int BCR_RATE0 = 0;

  // ---------------------------------------------------------------
  // code_and_rate_reg write fields and read mask, own_address_reg fields
  // ---------------------------------------------------------------
  localparam int CRR_SEL     = 0;
  localparam int CRR_EXT     = 1;
  localparam int OAR_BCAST   = 0;
  localparam logic [7:0] CODE_MASK = 8'hF8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BCR_RST = 8'h00;
  localparam logic [7:0] SBR_RST = 8'h00;
  localparam logic [1:0] CRR_RST = 2'h1;
  localparam logic [7:0] OAR_RST = 8'h00;

  // ---------------------------------------------------------------
  // state codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_BUS_ERR   = 8'h00;
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RSTART    = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK  = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST  = 8'h38;
  localparam logic [7:0] ST_NONE      = 8'hF8;

  // ---------------------------------------------------------------
  // bit timing: each bit is four quarter ticks
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int MAX_BPS     = 400_000;
  localparam int BIT_DIV_R0  = 256;
  localparam int BIT_DIV_R1  = 224;
  localparam int BIT_DIV_R2  = 192;
  localparam int BIT_DIV_R3  = 160;
  localparam int BIT_DIV_R5  = 120;
  localparam int BIT_DIV_R6  = 60;
  localparam int BIT_DIV_T1  = 96;
  localparam logic [12:0] QTR_R0 = 13'(BIT_DIV_R0 / 4);
  localparam logic [12:0] QTR_R1 = 13'(BIT_DIV_R1 / 4);
  localparam logic [12:0] QTR_R2 = 13'(BIT_DIV_R2 / 4);
  localparam logic [12:0] QTR_R3 = 13'(BIT_DIV_R3 / 4);
  localparam logic [12:0] QTR_R5 = 13'(BIT_DIV_R5 / 4);
  localparam logic [12:0] QTR_R6 = 13'(BIT_DIV_R6 / 4);
  localparam logic [12:0] QTR_T1 = 13'(BIT_DIV_T1 / 4);
  localparam logic [8:0]  T1_SPAN = 9'h100;
  // least quarter period that keeps the bus at or below the top rate
  localparam logic [12:0] MIN_QTR_CYC =
    13'((CLK_HZ + 4 * MAX_BPS - 1) / (4 * MAX_BPS));

endpackage : twmtc_pkg

/* rtl/twmtc_fifo.sv */
// byte fifo with registered read data
`timescale 1ns/10ps
module twmtc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         empty;
  logic         full;
  logic         push;
  logic         pop;

  assign empty        = (wr_q == rd_q);
  assign full         = (wr_q[AW] != rd_q[AW])
                        && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready_out = !full;
  assign push         = in_valid_in && !full;
  assign pop          = !empty && (!out_valid_out || out_ready_in);

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_q[rd_q[AW-1:0]];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end

endmodule : twmtc_fifo

/* verification/twmtc_assertions.sv */
// port checker for the two-wire master transmitter controller
`timescale 1ns/10ps
module twmtc_assertions (
  input wire logic       MCLK_IN,
  input wire logic       SYS_RST_IN,
  input wire logic [7:0] SFR_ADDR_IN,
  input wire logic       SFR_WR_IN,
  input wire logic [7:0] SFR_WDATA_IN,
  input wire logic [7:0] SFR_RDATA_OUT,
  input wire logic       SERIAL_IRQ_OUT,
  input wire logic       SCL_OUT,
  input wire logic       SCL_OE_OUT,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_OUT,
  input wire logic [7:0] CAP_DATA_OUT,
  input wire logic       CAP_VALID_OUT,
  input wire logic       CAP_READY_IN
);
  logic [7:0] ctl_q;
  // shadow of the control bits that only software may change
  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN)
      ctl_q <= 8'h00;
    else if (SFR_WR_IN && SFR_ADDR_IN == twmtc_pkg::BCR_ADDR)
      ctl_q <= SFR_WDATA_IN;
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  chk_scl_never_high: assert property (!SCL_OUT)
    else $error("scl driven high");
  chk_sda_never_high: assert property (!SDA_OUT)
    else $error("sda driven high");
  chk_off_lines_free: assert property (
    !ctl_q[6] && !$past(ctl_q[6]) |-> !SCL_OE_OUT && !SDA_OE_OUT)
    else $error("disabled engine pulls a line");
  chk_ctrl_bits_kept: assert property (
    $past(SFR_ADDR_IN) == twmtc_pkg::BCR_ADDR && !$past(SFR_WR_IN)
    |-> (SFR_RDATA_OUT & 8'hC7) == (ctl_q & 8'hC7))
    else $error("enable or rate bits changed");
  chk_code_low_zero: assert property (
    $past(SFR_ADDR_IN) == twmtc_pkg::CRR_ADDR |-> SFR_RDATA_OUT[2:0] == 3'h0)
    else $error("state code low bits not zero");
  chk_irq_code_valid: assert property (
    SERIAL_IRQ_OUT && $past(SERIAL_IRQ_OUT)
    && $past(SFR_ADDR_IN) == twmtc_pkg::CRR_ADDR
    |-> SFR_RDATA_OUT != twmtc_pkg::ST_NONE)
    else $error("interrupt with no state code");
  chk_scl_held_flag: assert property (
    SERIAL_IRQ_OUT && $past(SERIAL_IRQ_OUT) && $past(SCL_OE_OUT)
    |-> SCL_OE_OUT)
    else $error("clock released while suspended");
  chk_cap_data_hold: assert property (
    CAP_VALID_OUT && !CAP_READY_IN |=> CAP_VALID_OUT && $stable(CAP_DATA_OUT))
    else $error("captured byte dropped before taken");
endmodule : twmtc_assertions

bind twmtc_top twmtc_assertions chk_u (
  .MCLK_IN, .SYS_RST_IN, .SFR_ADDR_IN, .SFR_WR_IN, .SFR_WDATA_IN,
  .SFR_RDATA_OUT, .SERIAL_IRQ_OUT, .SCL_OUT, .SCL_OE_OUT, .SDA_OUT,
  .SDA_OE_OUT, .CAP_DATA_OUT, .CAP_VALID_OUT, .CAP_READY_IN
);

/* verification/twmtc_slave_model.sv */
// behavioural slave that acknowledges the addressed byte
`timescale 1ns/10ps
module twmtc_slave_model (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  input  wire logic ack_en_in,
  output logic      sda_oe_out
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int   edges = 0;
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (scl_in && sda_q && !sda_in)
      edges <= 0;
    else if (scl_q && !scl_in)
      edges <= edges + 1;
  end
  // ninth bit pulled low as acknowledge, released otherwise
  assign sda_oe_out = ack_en_in && edges == 9;
endmodule : twmtc_slave_model

/* verification/two_wire_master_tx_controller_bench.sv */
// self-checking bench for the two-wire master transmitter controller
`timescale 1ns/10ps
module two_wire_master_tx_controller_bench;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic       wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic       tick = 1'b0;
  logic       cap_ready = 1'b0;
  logic       ack_en = 1'b1;
  logic [7:0] rdata, cap_data, d;
  logic       irq, scl_oe, sda_oe, slv_oe, cap_valid;
  wire        scl = ~scl_oe;
  wire        sda = ~sda_oe & ~slv_oe;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cyc = 0;

  twmtc_top dut_u (.MCLK_IN(mclk), .SYS_RST_IN(rst), .SFR_ADDR_IN(addr),
    .SFR_WR_IN(wr), .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata),
    .SERIAL_IRQ_OUT(irq), .T1_RELOAD_IN(8'h00), .EXT_TICK_IN(tick),
    .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(), .SCL_OE_OUT(scl_oe),
    .SDA_OUT(), .SDA_OE_OUT(sda_oe), .CAP_DATA_OUT(cap_data),
    .CAP_VALID_OUT(cap_valid), .CAP_READY_IN(cap_ready));
  twmtc_slave_model slv_u (.clk_in(mclk), .scl_in(scl), .sda_in(sda),
    .ack_en_in(ack_en), .sda_oe_out(slv_oe));

  always #10 mclk = ~mclk;
  always begin
    repeat (40) @(negedge mclk);
    tick = 1'b1;
    @(negedge mclk);
    tick = 1'b0;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge mclk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
    @(negedge mclk);
    addr = a;
    @(negedge mclk);
    d = rdata;
  endtask : rd_reg
  task automatic wait_irq();
    for (int i = 0; i < 5000 && irq !== 1'b1; i++) @(negedge mclk);
  endtask : wait_irq

  task automatic test_regs();
    rd_reg(8'hA0); chk("control", 8'h00, d);
    rd_reg(8'hA2); chk("code", 8'hF8, d);
    wr_reg(8'hA3, 8'hA5);
    rd_reg(8'hA3); chk("own", 8'hA5, d);
    wr_reg(8'hA1, 8'h5A);
    rd_reg(8'hA1); chk("shift", 8'h00, d);
  endtask : test_regs

  task automatic test_xfer(input logic a, input logic [7:0] code,
                           input logic [7:0] crr, input logic [7:0] rt);
    ack_en = a;
    wr_reg(8'hA2, crr);
    rd_reg(8'hA2); chk("code", 8'hF8, d);
    wr_reg(8'hA0, 8'h40 | rt);
    wr_reg(8'hA0, 8'h60 | rt);
    wait_irq();
    rd_reg(8'hA2); chk("code", 8'h08, d);
    rd_reg(8'hA0); chk("control", 8'h68 | rt, d);
    wr_reg(8'hA1, 8'hA4);
    rd_reg(8'hA1); chk("shift", 8'hA4, d);
    wr_reg(8'hA0, 8'h40 | rt);
    @(negedge mclk);
    chk("irq", 8'h00, {7'h00, irq});
    wait_irq();
    rd_reg(8'hA2); chk("code", code, d);
    rd_reg(8'hA1); chk("shift", 8'hA4, d);
    chk("capture", 8'hA4, cap_data);
    chk("capvalid", 8'h01, {7'h00, cap_valid});
    cap_ready = 1'b1;
    @(negedge mclk);
    cap_ready = 1'b0;
    wr_reg(8'hA0, 8'h60 | rt);
    @(negedge mclk);
    wait_irq();
    rd_reg(8'hA2); chk("code", 8'h10, d);
    wr_reg(8'hA0, 8'h50 | rt);
    d = 8'hFF;
    for (int i = 0; i < 3000 && d[4] !== 1'b0; i++) rd_reg(8'hA0);
    chk("control", 8'h40 | rt, d);
    rd_reg(8'hA2); chk("code", 8'hF8, d);
    chk("lines", 8'h00, {6'h00, scl_oe, sda_oe});
  endtask : test_xfer

  task automatic report_and_stop();
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    test_regs();
    test_xfer(1'b1, 8'h18, 8'h03, 8'h00);
    test_xfer(1'b0, 8'h20, 8'h01, 8'h82);
    report_and_stop();
  end
endmodule : two_wire_master_tx_controller_bench
